// ==== core/oec_consts.vh ====
// Purpose: constants for the output enable control block
// Assumes: 200 MHz reference clock
// Notes: register offsets and codes used by the register port
`ifndef OEC_CONSTS_VH
`define OEC_CONSTS_VH

// ============================================================
// register offsets (byte addresses)
`define OEC_ADDR_CMD 8'h00
`define OEC_ADDR_STATUS 8'h04
`define OEC_ADDR_PINCFG 8'h08
`define OEC_ADDR_LOAD 8'h0C
`define OEC_ADDR_VSET 8'h10
`define OEC_ADDR_ISET 8'h14
`define OEC_ADDR_VOUT 8'h18
`define OEC_ADDR_IOUT 8'h1C
`define OEC_ADDR_VPROT 8'h20
`define OEC_ADDR_IPROT 8'h24
`define OEC_ADDR_SAVE 8'h28
`define OEC_ADDR_VLIM 8'h2C
`define OEC_ADDR_ILIM 8'h30
`define OEC_ADDR_SETUP 8'h34
`define OEC_ADDR_SER 8'h38
`define OEC_ADDR_NV_OUT 8'h3C
`define OEC_ADDR_NV_IF 8'h40
`define OEC_ADDR_NV_LIM 8'h44
`define OEC_ADDR_NV_SER 8'h48

// ============================================================
// command register codes (bit 0 is the boolean value)
`define OEC_CMD_OFF 1'b0
`define OEC_CMD_ON 1'b1

// ============================================================
// remote pin configuration codes
`define OEC_PIN_HIGH_ENABLES 3'h0
`define OEC_PIN_LOW_ENABLES 3'h1
`define OEC_PIN_HIGH_FORCES_OFF 3'h2
`define OEC_PIN_LOW_FORCES_OFF 3'h3
`define OEC_PIN_LOW_PULSE_LATCH_OFF 3'h4
`define OEC_PIN_DISABLED 3'h5

// ============================================================
// load type codes
`define OEC_LOAD_ACTIVE 2'h0
`define OEC_LOAD_RESISTIVE 2'h1
`define OEC_LOAD_BATTERY 2'h2

// ============================================================
// save group select bits in the save register
`define OEC_SAVE_IF_BIT 0
`define OEC_SAVE_SER_BIT 1
`define OEC_SAVE_LIM_BIT 2
`define OEC_SAVE_OUT_BIT 3

// ============================================================
// field positions
`define OEC_SETUP_ADDR_LSB 16
`define OEC_NV_IF_PIN_LSB 24
`define OEC_STAT_VSRC_BIT 1
`define OEC_STAT_LATCH_BIT 2

// ============================================================
// low protection level and timing
`define OEC_LOW_PROT 16'h0010
`define OEC_LATCH_TIME_NS 100000
`define OEC_CLK_PERIOD_NS 5

`endif

// ==== core/oec_output_ctrl.v ====
// Purpose: output enable control with remote pin gating and power-up save
// Assumes: register port master never overlaps read and write strobes
// Notes: non-volatile storage is modelled as snapshot registers read back by software
//
// Overview of operation
// R1 - save interface group: bus address and system setup variables kept for power-up
// R2 - save serial group: link state, baud, pacing and echo kept
// R3 - save limits group: voltage, current limits and protection maxima kept; the code keeps only the low 16 bits of vlim_reg and ilim_reg
// R4 - save output group: on/off state and load type kept
// R5 - command 0 disables, 1 enables; output comes up enabled by default
// R6 - passive load off: save setpoints, zero main quantity, low protection
// R7 - on restores saved setpoints; setpoint reads show saved values while off
// R8 - host should use current mode at zero current for active loads
// R9 - output state read returns 0 when disabled, 1 when enabled
// R10 - pin setting defaults to high forces off, saved with interface group
// R11 - high enables: pin high enables, pin low disables
// R12 - low enables: pin low enables, pin high disables
// R13 - high forces off: pin high holds off, low allows command enable
// R14 - low forces off: pin low holds off, high allows command enable
// R15 - latching: low at least 100 us turns off; only on command re-enables
// R16 - disabled pin setting ignores every pin level
// R17 - high and low enables settings ignore on and off commands
// R18 - pin setting read returns the selected setting code
// R19 - load type select chooses active, resistive or battery handling
// R20 - load type read reports the configured load type
// R21 - pin synchronised and low time counted before it acts
`timescale 1ns/1ps
`include "oec_consts.vh"

module oec_output_ctrl #(
	parameter DW = 16,
	parameter LATCH_CYCLES = `OEC_LATCH_TIME_NS / `OEC_CLK_PERIOD_NS
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_nrst,
	// register port
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	// remote on/off pin and panel
	input wire i_remote_pin,
	input wire i_panel_on,
	// outputs to the analog section
	output reg o_output_en,
	output reg [DW-1:0] o_vout,
	output reg [DW-1:0] o_iout,
	output reg [DW-1:0] o_vprot,
	output reg [DW-1:0] o_iprot,
	output reg o_save_pulse
);

	// ============================================================
	// state
	reg cmd_en_reg;
	reg vsrc_reg;
	reg latched_off_reg;
	reg [2:0] pincfg_reg;
	reg [1:0] load_reg;
	reg [DW-1:0] vset_reg;
	reg [DW-1:0] iset_reg;
	reg [DW-1:0] vprot_set_reg;
	reg [DW-1:0] iprot_set_reg;
	reg [31:0] vlim_reg;
	reg [31:0] ilim_reg;
	reg [31:0] setup_reg;
	reg [31:0] ser_reg;
	reg [31:0] nv_out_reg;
	reg [31:0] nv_if_reg;
	reg [31:0] nv_lim_reg;
	reg [31:0] nv_ser_reg;
	reg [31:0] rdata_next;
	reg en_next;
	wire pin_level;
	wire low_long;
	wire wr_cmd;
	wire wr_save;
	wire pin_governs;

	// ============================================================
	// pin filter; threshold division truncates, and the filter fires one cycle past it so the low is never shorter than required
	oec_pin_filter #(
		.CNT_W(16),
		.LOW_CYCLES(LATCH_CYCLES[15:0])
	) u_pin_filter (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_pin(i_remote_pin),
		.o_pin_level(pin_level),
		.o_low_long(low_long)
	);

	assign wr_cmd = i_wr && (i_addr == `OEC_ADDR_CMD);
	assign wr_save = i_wr && (i_addr == `OEC_ADDR_SAVE);
	// only the pin decides in the two level-enable settings
	assign pin_governs = (pincfg_reg == `OEC_PIN_HIGH_ENABLES) ||
		(pincfg_reg == `OEC_PIN_LOW_ENABLES);

	// ============================================================
	// command enable and latch-off state
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cmd_en_reg <= 1'b1; // R5
			latched_off_reg <= 1'b0;
		end else begin
			if (wr_cmd && !pin_governs) begin
				cmd_en_reg <= i_wdata[0]; // R17
			end else if (i_panel_on && !pin_governs) begin
				cmd_en_reg <= `OEC_CMD_ON;
			end
			// latch sets on a long low; an on command clears it, the set wins a tie
			if (pincfg_reg == `OEC_PIN_LOW_PULSE_LATCH_OFF && low_long) begin
				latched_off_reg <= 1'b1; // R15
			end else if (wr_cmd && i_wdata[0] == `OEC_CMD_ON) begin
				latched_off_reg <= 1'b0; // R15
			end else if (pincfg_reg != `OEC_PIN_LOW_PULSE_LATCH_OFF) begin
				latched_off_reg <= 1'b0;
			end
		end
	end

	// ============================================================
	// effective enable from pin setting
	always @* begin
		case (pincfg_reg)
			`OEC_PIN_HIGH_ENABLES: en_next = pin_level; // R11
			`OEC_PIN_LOW_ENABLES: en_next = !pin_level; // R12
			`OEC_PIN_HIGH_FORCES_OFF: en_next = cmd_en_reg && !pin_level; // R13
			`OEC_PIN_LOW_FORCES_OFF: en_next = cmd_en_reg && pin_level; // R14
			`OEC_PIN_LOW_PULSE_LATCH_OFF: en_next = cmd_en_reg && !latched_off_reg; // R15
			`OEC_PIN_DISABLED: en_next = cmd_en_reg; // R16
			default: en_next = cmd_en_reg;
		endcase
	end

	// ============================================================
	// configuration registers written by software
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			pincfg_reg <= `OEC_PIN_HIGH_FORCES_OFF; // R10
			load_reg <= `OEC_LOAD_RESISTIVE;
			vsrc_reg <= 1'b1;
			vset_reg <= {DW{1'b0}};
			iset_reg <= {DW{1'b0}};
			vprot_set_reg <= {DW{1'b0}};
			iprot_set_reg <= {DW{1'b0}};
			vlim_reg <= 32'h0000_0000;
			ilim_reg <= 32'h0000_0000;
			setup_reg <= 32'h0000_0000;
			ser_reg <= 32'h0000_0000;
		end else if (i_wr) begin
			case (i_addr)
				`OEC_ADDR_PINCFG: begin
					if (i_wdata[2:0] <= `OEC_PIN_DISABLED) begin
						pincfg_reg <= i_wdata[2:0];
					end
				end
				`OEC_ADDR_LOAD: begin
					if (i_wdata[1:0] <= `OEC_LOAD_BATTERY) begin
						load_reg <= i_wdata[1:0]; // R19
					end
				end
				`OEC_ADDR_STATUS: vsrc_reg <= i_wdata[`OEC_STAT_VSRC_BIT];
				// set-points are held here and survive an off period, R7
				`OEC_ADDR_VSET: vset_reg <= i_wdata[DW-1:0];
				`OEC_ADDR_ISET: iset_reg <= i_wdata[DW-1:0];
				`OEC_ADDR_VPROT: vprot_set_reg <= i_wdata[DW-1:0];
				`OEC_ADDR_IPROT: iprot_set_reg <= i_wdata[DW-1:0];
				`OEC_ADDR_VLIM: vlim_reg <= i_wdata;
				`OEC_ADDR_ILIM: ilim_reg <= i_wdata;
				`OEC_ADDR_SETUP: setup_reg <= i_wdata;
				`OEC_ADDR_SER: ser_reg <= i_wdata;
				default: ;
			endcase
		end
	end

	// ============================================================
	// analog drive; passive loads are parked at zero while off
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_output_en <= 1'b1;
			o_vout <= {DW{1'b0}};
			o_iout <= {DW{1'b0}};
			o_vprot <= {DW{1'b0}};
			o_iprot <= {DW{1'b0}};
		end else begin
			o_output_en <= en_next; // R5
			if (en_next || load_reg == `OEC_LOAD_ACTIVE) begin
				o_vout <= vset_reg; // R7
				o_iout <= iset_reg;
				o_vprot <= vprot_set_reg;
				o_iprot <= iprot_set_reg;
			end else if (vsrc_reg) begin
				o_vout <= {DW{1'b0}}; // R6
				o_iout <= iset_reg;
				o_vprot <= vprot_set_reg;
				o_iprot <= `OEC_LOW_PROT;
			end else begin
				o_vout <= vset_reg; // R6
				o_iout <= {DW{1'b0}};
				o_vprot <= `OEC_LOW_PROT;
				o_iprot <= iprot_set_reg;
			end
		end
	end

	// ============================================================
	// power-up snapshots, one per group
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			nv_out_reg <= 32'h0000_0001;
			nv_if_reg <= 32'h0200_0000;
			nv_lim_reg <= 32'h0000_0000;
			nv_ser_reg <= 32'h0000_0000;
			o_save_pulse <= 1'b0;
		end else begin
			o_save_pulse <= wr_save;
			if (wr_save && i_wdata[`OEC_SAVE_IF_BIT]) begin
				nv_if_reg <= {5'h00, pincfg_reg, setup_reg[23:0]}; // R1 R10
			end
			if (wr_save && i_wdata[`OEC_SAVE_SER_BIT]) begin
				nv_ser_reg <= ser_reg; // R2
			end
			if (wr_save && i_wdata[`OEC_SAVE_LIM_BIT]) begin
				nv_lim_reg <= {vlim_reg[15:0], ilim_reg[15:0]}; // R3
			end
			if (wr_save && i_wdata[`OEC_SAVE_OUT_BIT]) begin
				nv_out_reg <= {28'h0000000, vsrc_reg, load_reg, o_output_en}; // R4
			end
		end
	end

	// ============================================================
	// read mux; unmapped addresses read zero
	always @* begin
		case (i_addr)
			`OEC_ADDR_CMD: rdata_next = {31'h0, cmd_en_reg};
			`OEC_ADDR_STATUS: rdata_next = {29'h0, latched_off_reg, vsrc_reg,
				o_output_en}; // R9
			`OEC_ADDR_PINCFG: rdata_next = {29'h0, pincfg_reg}; // R18
			`OEC_ADDR_LOAD: rdata_next = {30'h0, load_reg}; // R20
			`OEC_ADDR_VSET: rdata_next = {{(32-DW){1'b0}}, vset_reg}; // R7
			`OEC_ADDR_ISET: rdata_next = {{(32-DW){1'b0}}, iset_reg}; // R7
			`OEC_ADDR_VOUT: rdata_next = {{(32-DW){1'b0}}, o_vout};
			`OEC_ADDR_IOUT: rdata_next = {{(32-DW){1'b0}}, o_iout};
			`OEC_ADDR_VPROT: rdata_next = {{(32-DW){1'b0}}, vprot_set_reg};
			`OEC_ADDR_IPROT: rdata_next = {{(32-DW){1'b0}}, iprot_set_reg};
			`OEC_ADDR_VLIM: rdata_next = vlim_reg;
			`OEC_ADDR_ILIM: rdata_next = ilim_reg;
			`OEC_ADDR_SETUP: rdata_next = setup_reg;
			`OEC_ADDR_SER: rdata_next = ser_reg;
			`OEC_ADDR_NV_OUT: rdata_next = nv_out_reg;
			`OEC_ADDR_NV_IF: rdata_next = nv_if_reg;
			`OEC_ADDR_NV_LIM: rdata_next = nv_lim_reg;
			`OEC_ADDR_NV_SER: rdata_next = nv_ser_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			o_rdata <= rdata_next;
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

endmodule // oec_output_ctrl

// ==== core/oec_pin_filter.v ====
// Purpose: synchronise the remote pin and time its low level
// Assumes: pin is asynchronous to the clock
// Notes: o_low_long is a level that holds while the low persists past the threshold
`timescale 1ns/1ps
`include "oec_consts.vh"

module oec_pin_filter #(
	parameter CNT_W = 16,
	parameter [CNT_W-1:0] LOW_CYCLES = 16'h4E20
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_nrst,
	// pin
	input wire i_pin,
	// filtered
	output reg o_pin_level,
	output reg o_low_long
);

	// ============================================================
	// two-stage synchroniser, first stage read only by second
	reg sync1_reg;
	reg sync2_reg;
	reg [CNT_W-1:0] low_cnt_reg;

	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= i_pin; // R21
			sync2_reg <= sync1_reg;
		end
	end

	// ============================================================
	// low duration counter; any high restarts it, so short glitches are dropped
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			low_cnt_reg <= {CNT_W{1'b0}};
			o_low_long <= 1'b0;
			o_pin_level <= 1'b1;
		end else begin
			o_pin_level <= sync2_reg;
			if (sync2_reg) begin
				low_cnt_reg <= {CNT_W{1'b0}}; // R21
				o_low_long <= 1'b0;
			end else if (low_cnt_reg < LOW_CYCLES) begin
				low_cnt_reg <= low_cnt_reg + 1'b1;
				o_low_long <= 1'b0;
			end else begin
				o_low_long <= 1'b1; // R15
			end
		end
	end

endmodule // oec_pin_filter

// ==== verification/oec_output_ctrl_props.sv ====
// Purpose: port-level checks for the output enable control block
// Assumes: one clock, synchronous active-low reset
// Notes: helper counters track pin setting and quiet time
`timescale 1ns/1ps
module oec_output_ctrl_props #(
	parameter DW = 16,
	parameter LATCH_CYCLES = 20000
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_nrst,
	// register port
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	// pin, panel and output
	input wire i_remote_pin,
	input wire i_panel_on,
	input wire o_output_en,
	input wire o_save_pulse
);
	// ============================================================
	// helper state
	reg [2:0] cfg_q;
	reg [3:0] age;
	reg [3:0] pq;
	reg [31:0] low_cnt;
	reg pin_d;
	wire ctl_wr = i_wr && (i_addr == 8'h00 || i_addr == 8'h08);
	wire age_clr = ctl_wr || i_panel_on;
	// quiet counters saturate so old history never wraps back into range
	always @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cfg_q <= 3'h2;
			age <= 4'h0;
			pq <= 4'h0;
			low_cnt <= 32'h0;
			pin_d <= 1'h1;
		end else begin
			if (i_wr && i_addr == 8'h08 && i_wdata[2:0] <= 3'h5)
				cfg_q <= i_wdata[2:0];
			age <= age_clr ? 4'h0 : (age == 4'hF ? age : age + 4'h1);
			pq <= (age_clr || i_remote_pin != pin_d) ? 4'h0 : (pq == 4'hF ? pq : pq + 4'h1);
			low_cnt <= i_remote_pin ? 32'h0 : low_cnt + 32'h1;
			pin_d <= i_remote_pin;
		end
	end
	// ============================================================
	// assertions
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	save_pulse_a: assert property (i_wr && i_addr == 8'h28 |=> o_save_pulse)
		else $error("save pulse missing after save write");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside read slot");
	en_status_a: assert property (i_rd && i_addr == 8'h04 |=> o_rdata[0] == $past(o_output_en))
		else $error("status enable bit wrong");
	cmd_on_a: assert property (cfg_q == 3'h5 && i_wr && i_addr == 8'h00 && !i_panel_on |=> ##1 o_output_en == $past(i_wdata[0], 2))
		else $error("output command not applied");
	hon_follow_a: assert property (cfg_q == 3'h0 && pq >= 4'h8 |-> o_output_en == i_remote_pin)
		else $error("enable not following high pin");
	lon_follow_a: assert property (cfg_q == 3'h1 && pq >= 4'h8 |-> o_output_en != i_remote_pin)
		else $error("enable not following low pin");
	high_forces_off_hold_a: assert property (cfg_q == 3'h2 && pq >= 4'h8 && i_remote_pin |-> !o_output_en)
		else $error("high pin did not hold output off");
	low_forces_off_hold_a: assert property (cfg_q == 3'h3 && pq >= 4'h8 && !i_remote_pin |-> !o_output_en)
		else $error("low pin did not hold output off");
	latch_off_a: assert property (cfg_q == 3'h4 && age >= 4'h3 &&
		low_cnt >= LATCH_CYCLES + 10 |-> !o_output_en)
		else $error("long low did not latch output off");
	glitch_reject_a: assert property (cfg_q == 3'h4 && age >= 4'h3 && $fell(o_output_en) |-> low_cnt >= LATCH_CYCLES)
		else $error("short low turned output off");
	dis_ignore_a: assert property (cfg_q == 3'h5 && age >= 4'h4 |-> $stable(o_output_en))
		else $error("disabled pin setting changed output");
	// ============================================================
	// covers
	cover property (o_save_pulse);
	cover property (cfg_q == 3'h4 && $fell(o_output_en));
	cover property (cfg_q == 3'h0 && pq >= 4'h8 && o_output_en);
endmodule // oec_output_ctrl_props

bind oec_output_ctrl oec_output_ctrl_props #(.DW(DW), .LATCH_CYCLES(LATCH_CYCLES)) u_props (
	.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_remote_pin(i_remote_pin),
	.i_panel_on(i_panel_on), .o_output_en(o_output_en), .o_save_pulse(o_save_pulse));

// ==== verification/oec_pin_src.sv ====
// Purpose: remote on/off contact seen from the pin
// Assumes: the pin has a pull-up inside the supply
// Notes: an open contact reads as high
`timescale 1ns/1ps
module oec_pin_src (
	// bench control
	input wire i_drive_en,
	input wire i_level,
	// remote pin
	output wire o_pin
);
	// released contact floats up to the pull-up level
	assign o_pin = i_drive_en ? i_level : 1'h1;
endmodule // oec_pin_src

// ==== verification/output_enable_control_tb_top.sv ====
// Purpose: self-checking bench for the output enable control block
// Assumes: latch count shortened to 20 cycles
// Notes: setpoints come from a fixed-seed shift register
`timescale 1ns/1ps
`include "oec_consts.vh"
`define CHK(n, e, g) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin \
	fails = fails + 1; $display("[FAIL] %0s exp %0h got %0h", n, e, g); end end
module output_enable_control_tb_top;
	// ============================================================
	// bench state
	reg clk = 1'h0, nrst = 1'h0, b_wr = 1'h0, b_rd = 1'h0, panel = 1'h0, pde = 1'h0, plv = 1'h1;
	reg [7:0] b_addr = 8'h00;
	reg [31:0] b_wdata = 32'h0;
	reg [15:0] seed = 16'h02F2, vs, is;
	reg [23:0] su;
	wire pin, en, sp;
	wire [31:0] rdata;
	wire [15:0] vout, iout, vprot, iprot;
	integer fails = 0, samples_checked = 0, i;
	oec_pin_src u_pin (.i_drive_en(pde), .i_level(plv), .o_pin(pin));
	oec_output_ctrl #(.LATCH_CYCLES(20)) u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(b_addr),
		.i_wdata(b_wdata), .i_wr(b_wr), .i_rd(b_rd), .o_rdata(rdata), .i_remote_pin(pin),
		.i_panel_on(panel), .o_output_en(en), .o_vout(vout), .o_iout(iout), .o_vprot(vprot),
		.o_iprot(iprot), .o_save_pulse(sp));
	// ============================================================
	// helpers
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function pin_en(input [2:0] c, input p);
		pin_en = (c == 3'h0) ? p : !p;
	endfunction
	task cyc(input integer n);
		begin repeat (n) @(posedge clk); #1; end
	endtask
	task wr_reg(input [7:0] a, input [31:0] d);
		begin @(posedge clk); b_wr <= 1'h1; b_addr <= a; b_wdata <= d; @(posedge clk); b_wr <= 1'h0; end
	endtask
	task rd_chk(input [7:0] a, input [31:0] e, input [63:0] n);
		begin
			@(posedge clk); b_rd <= 1'h1; b_addr <= a; @(posedge clk); b_rd <= 1'h0; #1;
			`CHK(n, e, rdata)
		end
	endtask
	task pin_set(input lv);
		begin @(posedge clk); pde <= 1'h1; plv <= lv; cyc(10); end
	endtask
	task final_report;
		begin
			if (fails == 0 && samples_checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// clock of 5 ns
	initial begin
		forever #2.5 clk = ~clk;
	end
	// hang guard well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		fails = fails + 1;
		final_report;
	end
	// ============================================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1;
		`CHK("en", 1'h1, en)
		@(posedge clk);
		nrst <= 1'h1;
		cyc(6);
		`CHK("en", 1'h0, en)
		rd_chk(`OEC_ADDR_PINCFG, 32'h2, "pincfg");
		rd_chk(`OEC_ADDR_LOAD, 32'h1, "load");
		pin_set(1'h0);
		wr_reg(`OEC_ADDR_CMD, 32'h1); cyc(3); `CHK("en", 1'h1, en)
		rd_chk(`OEC_ADDR_STATUS, 32'h3, "status");
		wr_reg(`OEC_ADDR_CMD, 32'h0); cyc(3); `CHK("en", 1'h0, en)
		@(posedge clk); panel <= 1'h1; @(posedge clk); panel <= 1'h0; cyc(4);
		`CHK("en", 1'h1, en)
		pin_set(1'h1); `CHK("en", 1'h0, en)
		for (i = 0; i < 2; i = i + 1) begin
			wr_reg(`OEC_ADDR_PINCFG, i); pin_set(1'h1);
			`CHK("en", pin_en(i, 1'h1), en)
			wr_reg(`OEC_ADDR_CMD, {31'h0, ~pin_en(i, 1'h1)}); cyc(3);
			`CHK("en", pin_en(i, 1'h1), en)
			pin_set(1'h0); `CHK("en", pin_en(i, 1'h0), en)
		end
		wr_reg(`OEC_ADDR_PINCFG, 32'h3); wr_reg(`OEC_ADDR_CMD, 32'h1); cyc(10);
		`CHK("en", 1'h0, en)
		pin_set(1'h1); wr_reg(`OEC_ADDR_CMD, 32'h1); cyc(3); `CHK("en", 1'h1, en)
		// low pulse latch: short glitch first, then a long low
		wr_reg(`OEC_ADDR_PINCFG, 32'h4); seed = lfsr(seed);
		@(posedge clk); plv <= 1'h0; repeat (2 + seed[2:0]) @(posedge clk); plv <= 1'h1; cyc(10);
		`CHK("en", 1'h1, en)
		pin_set(1'h0); cyc(30); `CHK("en", 1'h0, en)
		rd_chk(`OEC_ADDR_STATUS, 32'h6, "status");
		pin_set(1'h1); `CHK("en", 1'h0, en)
		wr_reg(`OEC_ADDR_CMD, 32'h1); cyc(3); `CHK("en", 1'h1, en)
		wr_reg(`OEC_ADDR_PINCFG, 32'h5);
		for (i = 0; i < 4; i = i + 1) begin
			pin_set(i[0]); `CHK("en", 1'h1, en)
		end
		// off parks the main quantity, on restores it
		for (i = 0; i < 4; i = i + 1) begin
			seed = lfsr(seed); vs = seed | 16'h1; seed = lfsr(seed); is = seed | 16'h1;
			wr_reg(`OEC_ADDR_STATUS, {30'h0, ~i[0], 1'h0});
			// first two passes resistive, last two battery: both park when off
			wr_reg(`OEC_ADDR_LOAD, {30'h0, i[1], ~i[1]});
			wr_reg(`OEC_ADDR_VSET, vs); wr_reg(`OEC_ADDR_ISET, is);
			wr_reg(`OEC_ADDR_CMD, 32'h1); wr_reg(`OEC_ADDR_CMD, 32'h0); cyc(3);
			`CHK("park", 16'h0, i[0] ? iout : vout)
			`CHK("prot", `OEC_LOW_PROT, i[0] ? vprot : iprot)
			rd_chk(`OEC_ADDR_VSET, {16'h0, vs}, "vset");
			wr_reg(`OEC_ADDR_CMD, 32'h1); cyc(3);
			`CHK("restore", i[0] ? is : vs, i[0] ? iout : vout)
		end
		for (i = 0; i < 3; i = i + 1) begin
			wr_reg(`OEC_ADDR_LOAD, i); rd_chk(`OEC_ADDR_LOAD, i, "load");
		end
		wr_reg(`OEC_ADDR_LOAD, 32'h3); rd_chk(`OEC_ADDR_LOAD, 32'h2, "load");
		wr_reg(`OEC_ADDR_STATUS, 32'h2); wr_reg(`OEC_ADDR_VSET, vs); wr_reg(`OEC_ADDR_LOAD, 32'h0);
		wr_reg(`OEC_ADDR_CMD, 32'h0); cyc(3); `CHK("active", vs, vout)
		wr_reg(`OEC_ADDR_ISET, 32'h0);
		wr_reg(`OEC_ADDR_LOAD, 32'h1);
		for (i = 0; i < 7; i = i + 1) begin
			wr_reg(`OEC_ADDR_PINCFG, i); rd_chk(`OEC_ADDR_PINCFG, i > 5 ? 5 : i, "pincfg");
		end
		// power-up save of every group
		seed = lfsr(seed); su = {seed, seed[7:0]}; wr_reg(`OEC_ADDR_SETUP, {8'h0, su});
		wr_reg(`OEC_ADDR_SER, {24'h0, seed[15:8]});
		wr_reg(`OEC_ADDR_VLIM, vs); wr_reg(`OEC_ADDR_ILIM, is); wr_reg(`OEC_ADDR_CMD, 32'h1);
		wr_reg(`OEC_ADDR_SAVE, 32'hF); #1; `CHK("save", 1'h1, sp)
		rd_chk(`OEC_ADDR_NV_IF, {5'h0, 3'h5, su}, "nv_if");
		rd_chk(`OEC_ADDR_NV_SER, {24'h0, seed[15:8]}, "nv_ser");
		rd_chk(`OEC_ADDR_NV_LIM, {vs, is}, "nv_lim");
		rd_chk(`OEC_ADDR_NV_OUT, 32'hB, "nv_out");
		rd_chk(8'h80, 32'h0, "unmapped");
		// second reset in mid-run: defaults and snapshots come back
		@(posedge clk); nrst <= 1'h0; cyc(3); `CHK("en", 1'h1, en)
		@(posedge clk); nrst <= 1'h1; cyc(6); `CHK("en", 1'h0, en)
		rd_chk(`OEC_ADDR_PINCFG, 32'h2, "pincfg");
		rd_chk(`OEC_ADDR_NV_IF, 32'h0200_0000, "nv_if");
		final_report;
	end
endmodule // output_enable_control_tb_top
